// [tmrc_regs.svh]
`ifndef TMRC_REGS_SVH
`define TMRC_REGS_SVH
// register byte offsets
`define TMRC_OFF_CTRL_A   8'h00
`define TMRC_OFF_CTRL_B   8'h04
`define TMRC_OFF_COUNT    8'h08
`define TMRC_OFF_CMP_A    8'h0c
`define TMRC_OFF_CMP_B    8'h10
`define TMRC_OFF_FLAG     8'h14
`define TMRC_OFF_MASK     8'h18
`define TMRC_OFF_ASYNC    8'h1c
`define TMRC_OFF_POWER    8'h20
// field positions
`define TMRC_CA_WGM0      0
`define TMRC_CA_WGM1      1
`define TMRC_CA_COMB_LO   4
`define TMRC_CA_COMA_LO   6
`define TMRC_CB_CS_LO     0
`define TMRC_CB_WGM2      3
`define TMRC_FL_OVF       0
`define TMRC_FL_MA        1
`define TMRC_FL_MB        2
`define TMRC_AS_SEL       5
`define TMRC_PW_OFF       0
// values
`define TMRC_BOTTOM       8'h00
`define TMRC_MAX          8'hff
`define TMRC_RESP_OKAY    2'b00
`define TMRC_RESP_SLVERR  2'b10
`define TMRC_WGM_NORMAL   3'h0
`define TMRC_WGM_PC_MAX   3'h1
`define TMRC_WGM_CTC      3'h2
`define TMRC_WGM_FP_MAX   3'h3
`define TMRC_WGM_PC_OCR   3'h5
`define TMRC_WGM_FP_OCR   3'h7
`define TMRC_CS_STOP      3'h0
`endif

// [tmrc_pkg.sv]
package tmrc_pkg;
	typedef struct packed {
		logic [1:0] com_a;
		logic [1:0] com_b;
		logic [2:0] wgm;
		logic [2:0] cs;
	} tmrc_cfg_s;
	typedef struct packed {
		logic ovf;
		logic ma;
		logic mb;
	} tmrc_evt_s;
endpackage

// [tmrc_core.sv]
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "tmrc_regs.svh"
// Overview of operation
// - counter and both compare registers are 8-bit, software readable and writable
// - every request appears in the flag register whatever its mask bit; the mask gates only irq_out
// - clock select zero stops the counter, no timer ticks
// - tick from system clock, or from oscillator pin when async select set
// - counter readable and writable whether a tick is present or not
// - software write to counter beats clear and count
// - each tick clears, increments or decrements counter by one per mode
// - bottom is signalled when counter becomes zero
// - maximum is reached when counter becomes 0xff
// - top is the fixed maximum or compare value A, by mode
// - waveform mode is two bits of control A plus one of control B
// - overflow flag set at a mode-dependent point, usable as interrupt
// - compare registers double-buffered in pwm modes only, and compared every cycle
// - match on channel A or B sets that channel's flag
// - compare output mode bits never change the counting sequence
// - output mode inverts pwm, or sets, clears, toggles in non-pwm modes
// - mode zero counts up, wraps max to zero, overflow when zero
// - mode two clears on match A, compare A not buffered
// - fast pwm counts up to max (mode 3) or A (mode 7), overflow at top
// - modes one and five count up and down, overflow at bottom
module tmrc_core
	import tmrc_pkg::*;
(
	input  wire logic        clk_sys_in,     // system clock
	input  wire logic        rst_n_in,       // sync reset, active low
	input  wire logic        osc_pin_in,     // oscillator clock pin, asynchronous
	input  wire logic [7:0]  s_axi_awaddr,   // write address
	input  wire logic        s_axi_awvalid,  // write address valid
	output logic             s_axi_awready,  // write address ready
	input  wire logic [31:0] s_axi_wdata,    // write data
	input  wire logic [3:0]  s_axi_wstrb,    // write strobes
	input  wire logic        s_axi_wvalid,   // write data valid
	output logic             s_axi_wready,   // write data ready
	output logic [1:0]       s_axi_bresp,    // write response
	output logic             s_axi_bvalid,   // write response valid
	input  wire logic        s_axi_bready,   // write response ready
	input  wire logic [7:0]  s_axi_araddr,   // read address
	input  wire logic        s_axi_arvalid,  // read address valid
	output logic             s_axi_arready,  // read address ready
	output logic [31:0]      s_axi_rdata,    // read data
	output logic [1:0]       s_axi_rresp,    // read response
	output logic             s_axi_rvalid,   // read data valid
	input  wire logic        s_axi_rready,   // read data ready
	output logic             irq_out,        // masked request level
	output logic             wave_out_a,     // compare output a
	output logic             wave_out_b      // compare output b
);
	// software state
	logic [7:0]  ctrl_a_r, ctrl_b_r, count_value_r, cmp_a_r, cmp_b_r, cmp_a_buf_r, cmp_b_buf_r;
	logic [2:0]  irq_flag_r, irq_mask_r;
	logic        async_sel_r, power_off_r, dir_down_r;
	logic [7:0]  awaddr_r, araddr_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;
	logic        aw_full_r, w_full_r;
	logic [31:0] rdata_r;
	logic [1:0]  rresp_r, bresp_r;
	logic        rvalid_r, bvalid_r;
	logic        osc_s1_r, osc_s2_r, osc_s3_r;
	logic        wave_a_r, wave_b_r;
	logic [7:0]  count_nxt;
	logic        dir_nxt;
	tmrc_cfg_s   cfg;
	tmrc_evt_s   evt;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a[7:2] == off[7:2]);
	endfunction

	// configuration fields; mode bits alone steer counting
	assign cfg.wgm   = {ctrl_b_r[`TMRC_CB_WGM2], ctrl_a_r[`TMRC_CA_WGM1],
		ctrl_a_r[`TMRC_CA_WGM0]};
	assign cfg.cs    = ctrl_b_r[`TMRC_CB_CS_LO +: 3];
	assign cfg.com_a = ctrl_a_r[`TMRC_CA_COMA_LO +: 2];
	assign cfg.com_b = ctrl_a_r[`TMRC_CA_COMB_LO +: 2];

	// mode decode
	wire mode_pc   = (cfg.wgm == `TMRC_WGM_PC_MAX) || (cfg.wgm == `TMRC_WGM_PC_OCR);
	wire mode_fp   = (cfg.wgm == `TMRC_WGM_FP_MAX) || (cfg.wgm == `TMRC_WGM_FP_OCR);
	wire mode_ctc  = (cfg.wgm == `TMRC_WGM_CTC);
	wire top_is_a  = (cfg.wgm == `TMRC_WGM_PC_OCR) || (cfg.wgm == `TMRC_WGM_FP_OCR);
	wire buffered  = mode_pc || mode_fp;
	// ctc compares against live register so a new top takes effect at once
	wire [7:0] cmp_a_eff = buffered ? cmp_a_buf_r : cmp_a_r;
	wire [7:0] cmp_b_eff = buffered ? cmp_b_buf_r : cmp_b_r;
	wire [7:0] top_val   = top_is_a ? cmp_a_eff : `TMRC_MAX;
	wire at_top    = (count_value_r == top_val);
	wire at_bottom = (count_value_r == `TMRC_BOTTOM);
	wire at_max    = (count_value_r == `TMRC_MAX);
	wire match_a   = (count_value_r == cmp_a_eff);
	wire match_b   = (count_value_r == cmp_b_eff);

	// tick source: oscillator edge is synchronised first, no prescaler kept
	wire osc_rise  = osc_s2_r & ~osc_s3_r;
	wire tick      = ~power_off_r && (cfg.cs != `TMRC_CS_STOP) &&
		(async_sel_r ? osc_rise : 1'b1);

	// axi write handshake
	wire wr_go     = aw_full_r && w_full_r && !bvalid_r;
	wire wr_count  = wr_go && hit(awaddr_r, `TMRC_OFF_COUNT) && wstrb_r[0];
	wire wr_flag   = wr_go && hit(awaddr_r, `TMRC_OFF_FLAG) && wstrb_r[0];
	assign s_axi_awready = !aw_full_r;
	assign s_axi_wready  = !w_full_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	// counter sequencing
	always_comb begin
		count_nxt = count_value_r;
		dir_nxt   = dir_down_r;
		if (tick) begin
			if (mode_pc) begin
				if (!dir_down_r && at_top) begin
					dir_nxt   = 1'b1;
					count_nxt = count_value_r - 8'h01;
				end else if (dir_down_r && at_bottom) begin
					dir_nxt   = 1'b0;
					count_nxt = count_value_r + 8'h01;
				end else begin
					count_nxt = dir_down_r ? count_value_r - 8'h01 : count_value_r + 8'h01;
				end
			end else if ((mode_ctc && match_a) || (mode_fp && at_top)) begin
				dir_nxt   = 1'b0;
				count_nxt = `TMRC_BOTTOM;
			end else begin
				dir_nxt   = 1'b0;
				count_nxt = count_value_r + 8'h01;
			end
		end
		if (wr_count)
			count_nxt = wdata_r[7:0];
	end

	// events per tick
	assign evt.ovf = tick && (mode_pc ? (dir_down_r && count_value_r == 8'h01) :
		mode_fp ? at_top : at_max);
	assign evt.ma  = tick && match_a;
	assign evt.mb  = tick && match_b;
	assign irq_out = |(irq_flag_r & irq_mask_r);

	// synchroniser; first stage read only by second
	always_ff @(posedge clk_sys_in) begin
		osc_s1_r <= osc_pin_in;
		osc_s2_r <= osc_s1_r;
		osc_s3_r <= osc_s2_r;
	end

	// counter and flags; hardware set wins over write-one clear
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			count_value_r <= `TMRC_BOTTOM;
			dir_down_r    <= 1'b0;
			irq_flag_r    <= 3'h0;
		end else begin
			count_value_r <= count_nxt;
			dir_down_r    <= dir_nxt;
			irq_flag_r    <= (irq_flag_r & ~(wr_flag ? wdata_r[2:0] : 3'h0)) |
				{evt.mb, evt.ma, evt.ovf};
		end
	end

	// buffered compare update at top (fast) or top turn (phase correct)
	wire buf_load = !buffered || (tick && at_top && (mode_fp || !dir_down_r));
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			cmp_a_buf_r <= `TMRC_BOTTOM;
			cmp_b_buf_r <= `TMRC_BOTTOM;
		end else if (buf_load) begin
			cmp_a_buf_r <= cmp_a_r;
			cmp_b_buf_r <= cmp_b_r;
		end
	end

	// waveform outputs, per channel
	function automatic logic wave_next(input logic cur, input logic [1:0] com,
		input logic m);
		wave_next = cur;
		// non-inverted pwm clears on match and sets at top; toggle falls through
		if (mode_fp && com != 2'h1) begin
			if (tick && at_top)
				wave_next = ~com[0];
			else if (m)
				wave_next = com[0];
		end else if (mode_pc) begin
			if (m)
				wave_next = dir_down_r ^ com[0];
		end else if (m) begin
			wave_next = (com == 2'b01) ? ~cur : (com == 2'b11);
		end
		if (com == 2'b00)
			wave_next = 1'b0;
	endfunction
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			wave_a_r <= 1'b0;
			wave_b_r <= 1'b0;
		end else begin
			wave_a_r <= wave_next(wave_a_r, cfg.com_a, evt.ma);
			wave_b_r <= wave_next(wave_b_r, cfg.com_b, evt.mb);
		end
	end
	assign wave_out_a = wave_a_r;
	assign wave_out_b = wave_b_r;

	// axi write channel capture
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			aw_full_r <= 1'b0;
			w_full_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= `TMRC_RESP_OKAY;
			awaddr_r  <= 8'h00;
			wdata_r   <= 32'h0;
			wstrb_r   <= 4'h0;
		end else begin
			if (s_axi_awvalid && !aw_full_r) begin
				aw_full_r <= 1'b1;
				awaddr_r  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_full_r) begin
				w_full_r <= 1'b1;
				wdata_r  <= s_axi_wdata;
				wstrb_r  <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_full_r <= 1'b0;
				w_full_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= (awaddr_r > `TMRC_OFF_POWER) ? `TMRC_RESP_SLVERR : `TMRC_RESP_OKAY;
			end else if (s_axi_bready)
				bvalid_r <= 1'b0;
		end
	end

	// register writes; low byte lane only carries data
	wire wr_lane = wr_go && wstrb_r[0];
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			ctrl_a_r    <= 8'h00;
			ctrl_b_r    <= 8'h00;
			cmp_a_r     <= 8'h00;
			cmp_b_r     <= 8'h00;
			irq_mask_r  <= 3'h0;
			async_sel_r <= 1'b0;
			power_off_r <= 1'b0;
		end else if (wr_lane) begin
			if (hit(awaddr_r, `TMRC_OFF_CTRL_A)) ctrl_a_r <= wdata_r[7:0];
			if (hit(awaddr_r, `TMRC_OFF_CTRL_B)) ctrl_b_r <= wdata_r[7:0];
			if (hit(awaddr_r, `TMRC_OFF_CMP_A))  cmp_a_r  <= wdata_r[7:0];
			if (hit(awaddr_r, `TMRC_OFF_CMP_B))  cmp_b_r  <= wdata_r[7:0];
			if (hit(awaddr_r, `TMRC_OFF_MASK))   irq_mask_r <= wdata_r[2:0];
			if (hit(awaddr_r, `TMRC_OFF_ASYNC))  async_sel_r <= wdata_r[`TMRC_AS_SEL];
			if (hit(awaddr_r, `TMRC_OFF_POWER))  power_off_r <= wdata_r[`TMRC_PW_OFF];
		end
	end

	// read mux
	logic [7:0] rd_byte;
	always_comb begin
		rd_byte = 8'h00;
		if (hit(s_axi_araddr, `TMRC_OFF_CTRL_A)) rd_byte = ctrl_a_r;
		if (hit(s_axi_araddr, `TMRC_OFF_CTRL_B)) rd_byte = ctrl_b_r;
		if (hit(s_axi_araddr, `TMRC_OFF_COUNT))  rd_byte = count_value_r;
		if (hit(s_axi_araddr, `TMRC_OFF_CMP_A))  rd_byte = cmp_a_r;
		if (hit(s_axi_araddr, `TMRC_OFF_CMP_B))  rd_byte = cmp_b_r;
		if (hit(s_axi_araddr, `TMRC_OFF_FLAG))   rd_byte = {5'h00, irq_flag_r};
		if (hit(s_axi_araddr, `TMRC_OFF_MASK))   rd_byte = {5'h00, irq_mask_r};
		if (hit(s_axi_araddr, `TMRC_OFF_ASYNC))  rd_byte = {2'h0, async_sel_r, 5'h00};
		if (hit(s_axi_araddr, `TMRC_OFF_POWER))  rd_byte = {7'h00, power_off_r};
	end
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0;
			rresp_r  <= `TMRC_RESP_OKAY;
		end else if (s_axi_arvalid && !rvalid_r) begin
			rvalid_r <= 1'b1;
			rdata_r  <= {24'h0, rd_byte};
			rresp_r  <= (s_axi_araddr > `TMRC_OFF_POWER) ? `TMRC_RESP_SLVERR : `TMRC_RESP_OKAY;
		end else if (s_axi_rready)
			rvalid_r <= 1'b0;
	end

	// checks
	property p_stop_holds;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		(cfg.cs == `TMRC_CS_STOP && !wr_count) |=> $stable(count_value_r);
	endproperty
	a_stop_holds: assert property (p_stop_holds) else $error("counter moved while stopped");
	property p_write_wins;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		wr_count |=> count_value_r == $past(wdata_r[7:0]);
	endproperty
	a_write_wins: assert property (p_write_wins) else $error("counter write lost");
	property p_normal_wrap;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		(tick && cfg.wgm == `TMRC_WGM_NORMAL && at_max && !wr_count) |=>
			(count_value_r == `TMRC_BOTTOM && irq_flag_r[`TMRC_FL_OVF]);
	endproperty
	a_normal_wrap: assert property (p_normal_wrap) else $error("normal wrap wrong");
	property p_ctc_clear;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		(tick && mode_ctc && match_a && !wr_count) |=> count_value_r == `TMRC_BOTTOM;
	endproperty
	a_ctc_clear: assert property (p_ctc_clear) else $error("ctc did not clear");
	property p_match_flag;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		evt.ma |=> irq_flag_r[`TMRC_FL_MA];
	endproperty
	a_match_flag: assert property (p_match_flag) else $error("match a flag not set");
	property p_irq_gate;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		(irq_mask_r == 3'h0) |-> !irq_out;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq passed mask");
	property p_pc_turn;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		(tick && mode_pc && !dir_down_r && at_top && !wr_count) |=> dir_down_r;
	endproperty
	a_pc_turn: assert property (p_pc_turn) else $error("no turn at top");
	property p_power_off;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		(power_off_r && !wr_count) |=> $stable(count_value_r);
	endproperty
	a_power_off: assert property (p_power_off) else $error("counted while powered off");
endmodule

// [tmrc_core_tb_top.sv]
`timescale 1ns/1ns
`include "tmrc_regs.svh"
module tmrc_core_tb_top;
	logic        clk_sys_in = 1'b0;
	logic        rst_n_in   = 1'b0;
	logic        osc        = 1'b0;
	logic [7:0]  awaddr     = 8'h00;
	logic [7:0]  araddr     = 8'h00;
	logic [31:0] wdata      = 32'h0;
	logic [3:0]  wstrb      = 4'h0;
	logic        awvalid    = 1'b0;
	logic        wvalid     = 1'b0;
	logic        bready     = 1'b0;
	logic        arvalid    = 1'b0;
	logic        rready     = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, irq_out, wa, wb;
	logic [1:0]  bresp, rresp, rs, ca, cb;
	logic [31:0] rdata, rv;
	logic [7:0]  v, ta, tb8, top;
	logic [2:0]  m;
	logic [2:0]  modes [5] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h7};
	logic        w0;
	int          error_cnt = 0;
	int          checks    = 0;
	int          n, tg, run, hb;

	tmrc_core u_tmrc_core (
		.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .osc_pin_in(osc),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_out(irq_out),
		.wave_out_a(wa), .wave_out_b(wb)
	);

	always #4 clk_sys_in = ~clk_sys_in;

	task automatic final_report();
		if (error_cnt == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// high time of one pulse: toggle lasts a period, pwm runs bottom..match or match..top
	function automatic int pulse_len(input logic [1:0] com, input logic [7:0] cmp,
		input logic [7:0] tp);
		if (com == 2'h1)
			return int'(tp) + 1;
		return com[0] ? int'(tp) - int'(cmp) : int'(cmp) + 1;
	endfunction

	// handshakes are judged at the falling edge, where ready is settled for the next rise
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int k;
		logic tka, tkw, tkb;
		k = 0;
		tkb = 1'b0;
		@(posedge clk_sys_in);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!tkb && k < 100) begin
			@(negedge clk_sys_in);
			tka = awvalid && awready;
			tkw = wvalid && wready;
			tkb = bvalid;
			rs = bresp;
			k++;
			@(posedge clk_sys_in);
			if (tka) awvalid <= 1'b0;
			if (tkw) wvalid <= 1'b0;
			if (tkb) bready <= 1'b0;
		end
		if (!tkb) check("wr_timeout", 0, 1);
	endtask

	task automatic rd(input logic [7:0] a);
		int k;
		logic tka, tkr;
		k = 0;
		tkr = 1'b0;
		@(posedge clk_sys_in);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!tkr && k < 100) begin
			@(negedge clk_sys_in);
			tka = arvalid && arready;
			tkr = rvalid;
			rv = rdata;
			rs = rresp;
			k++;
			@(posedge clk_sys_in);
			if (tka) arvalid <= 1'b0;
			if (tkr) rready <= 1'b0;
		end
		if (!tkr) check("rd_timeout", 0, 1);
	endtask

	// watchdog, far beyond the expected run length
	initial begin
		#(8 * 60000);
		error_cnt++;
		final_report();
	end

	initial begin
		v = 8'($urandom(58766));
		repeat (20) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		// every register comes up zero
		for (int a = 0; a <= 8'h20; a += 4) begin
			rd(8'(a));
			check("reset_value", rv, 32'h0);
		end
		check("wave_a_idle", wa, 1'b0);
		// unmapped place is refused both ways
		rd(8'h24);
		check("unmapped_rresp", rs, `TMRC_RESP_SLVERR);
		check("unmapped_rdata", rv, 32'h0);
		wr(8'h24, 32'h5a);
		check("unmapped_bresp", rs, `TMRC_RESP_SLVERR);
		// 8-bit registers, upper bits dropped; stopped counter holds its value
		for (int a = `TMRC_OFF_COUNT; a <= `TMRC_OFF_CMP_B; a += 4) begin
			rv = $urandom;
			v = rv[7:0];
			wr(8'(a), rv);
			repeat (20) @(posedge clk_sys_in);
			rd(8'(a));
			check("reg_rw", rv, {24'h0, v});
		end
		// powered-off module does not count even with a clock selected
		wr(`TMRC_OFF_COUNT, {24'h0, v});
		wr(`TMRC_OFF_POWER, 32'h1);
		wr(`TMRC_OFF_CTRL_B, 32'h1);
		repeat (30) @(posedge clk_sys_in);
		rd(`TMRC_OFF_COUNT);
		check("power_off_hold", rv, {24'h0, v});
		wr(`TMRC_OFF_POWER, 32'h0);
		// write to a running counter wins over the tick
		v = 8'($urandom);
		wr(`TMRC_OFF_COUNT, {24'h0, v});
		rd(`TMRC_OFF_COUNT);
		check("run_write", 8'(rv[7:0] - v) inside {[1:12]}, 1);
		// overflow in mode 0: unmasked raises the request, masked stays quiet
		wr(`TMRC_OFF_CTRL_B, 32'h0);
		wr(`TMRC_OFF_COUNT, 32'hf0);
		wr(`TMRC_OFF_FLAG, 32'h7);
		wr(`TMRC_OFF_MASK, 32'h1);
		wr(`TMRC_OFF_CTRL_B, 32'h1);
		n = 0;
		while (irq_out !== 1'b1 && n < 60) begin
			@(negedge clk_sys_in);
			n++;
		end
		check("ovf_irq_time", n inside {[8:18]}, 1);
		wr(`TMRC_OFF_CTRL_B, 32'h0);
		rd(`TMRC_OFF_FLAG);
		check("ovf_flag", rv[0], 1'b1);
		wr(`TMRC_OFF_FLAG, 32'h1);
		rd(`TMRC_OFF_FLAG);
		check("ovf_clear", {rv[0], irq_out}, 2'b00);
		wr(`TMRC_OFF_MASK, 32'h0);
		wr(`TMRC_OFF_CTRL_B, 32'h1);
		repeat (300) @(posedge clk_sys_in);
		check("ovf_masked_irq", irq_out, 1'b0);
		wr(`TMRC_OFF_CTRL_B, 32'h0);
		rd(`TMRC_OFF_FLAG);
		check("ovf_masked_flag", rv[0], 1'b1);
		// oscillator pin clocks the counter once per rising edge, idle pin no ticks
		v = 8'($urandom);
		wr(`TMRC_OFF_COUNT, {24'h0, v});
		wr(`TMRC_OFF_ASYNC, 32'h20);
		wr(`TMRC_OFF_CTRL_B, 32'h1);
		repeat (10) begin
			repeat (4) @(posedge clk_sys_in);
			osc <= 1'b1;
			repeat (4) @(posedge clk_sys_in);
			osc <= 1'b0;
		end
		repeat (8) @(posedge clk_sys_in);
		rd(`TMRC_OFF_COUNT);
		check("osc_count", rv, {24'h0, 8'(v + 8'd10)});
		wr(`TMRC_OFF_CTRL_B, 32'h0);
		wr(`TMRC_OFF_ASYNC, 32'h0);
		// each waveform mode but 0: count bounded by top, flags as the mode says
		foreach (modes[i]) begin
			m = modes[i];
			ta = 8'($urandom_range(79, 16));
			tb8 = 8'($urandom_range(ta - 1, 1));
			ca = (m == `TMRC_WGM_CTC) ? 2'h1 : 2'($urandom);
			cb = 2'($urandom);
			top = (m == `TMRC_WGM_CTC || m[2]) ? ta : `TMRC_MAX;
			// buffers are loaded in mode 0 where they are live
			wr(`TMRC_OFF_CTRL_A, 32'h0);
			wr(`TMRC_OFF_CMP_A, {24'h0, ta});
			wr(`TMRC_OFF_CMP_B, {24'h0, tb8});
			wr(`TMRC_OFF_COUNT, 32'h0);
			wr(`TMRC_OFF_FLAG, 32'h7);
			wr(`TMRC_OFF_CTRL_A, {24'h0, ca, cb, 2'b00, m[1:0]});
			wr(`TMRC_OFF_CTRL_B, {28'h0, m[2], 3'h1});
			w0 = wa;
			tg = 0;
			run = 0;
			hb = -1;
			repeat (600) begin
				@(negedge clk_sys_in);
				if (wa !== w0) tg++;
				w0 = wa;
				// last complete high pulse on channel b; a pulse cut by the window start is replaced
				if (wb === 1'b1) run++;
				else begin
					if (run > 0) hb = run;
					run = 0;
				end
			end
			if (m == `TMRC_WGM_CTC) check("ctc_toggle", tg >= 2, 1);
			if (m == `TMRC_WGM_CTC && cb != 2'h1) check("ctc_level_b", wb, cb == 2'h3);
			if ((m == `TMRC_WGM_CTC && cb == 2'h1) || (m[1:0] == 2'h3 && cb != 2'h0))
				check("pulse_b", hb, pulse_len(cb, tb8, top));
			repeat (6) begin
				rd(`TMRC_OFF_COUNT);
				check("count_le_top", rv <= {24'h0, top}, 1);
			end
			wr(`TMRC_OFF_CTRL_B, 32'h0);
			rd(`TMRC_OFF_FLAG);
			check("mode_flags", rv, {29'h0, 2'b11, m != `TMRC_WGM_CTC});
		end
		final_report();
	end
endmodule
